// file: logic/vic_pkg.sv
// Shared constants, offsets and helpers for the vectored interrupt cascade unit
package vic_pkg;

   // ==========================================================
   // Sizes
   // ==========================================================
   localparam int unsigned POS_N = 16;
   localparam int unsigned IDX_W = 4;
   localparam int unsigned ADDR_W = 5;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [4:0] OFS_HVCT = 5'h00;
   localparam logic [4:0] OFS_VBASE = 5'h01;
   localparam logic [4:0] OFS_PEND_L = 5'h06;
   localparam logic [4:0] OFS_PEND_H = 5'h07;
   localparam logic [4:0] OFS_INSRV_L = 5'h08;
   localparam logic [4:0] OFS_INSRV_H = 5'h09;
   localparam logic [4:0] OFS_MASK_L = 5'h0A;
   localparam logic [4:0] OFS_MASK_H = 5'h0B;
   localparam logic [4:0] OFS_CASC_L = 5'h0C;
   localparam logic [4:0] OFS_CASC_H = 5'h0D;
   localparam logic [4:0] OFS_MODE = 5'h10;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int unsigned MODE_FREEZE_BIT = 3;
   localparam int unsigned MODE_FIXED_BIT = 7;
   localparam logic [7:0] MODE_USED = 8'h88;

   // ==========================================================
   // Reset values and codes
   // ==========================================================
   localparam logic [7:0] RST_VBASE = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [15:0] RST_MASK = 16'hFFFF;
   localparam logic [15:0] RST_FLAGS = 16'h0000;
   localparam logic [3:0] RST_CNT = 4'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] CASC_TOP = 4'hF;
   localparam logic [3:0] SPURIOUS_IDX = 4'hF;

   // Lowest set index with a found flag on top
   function automatic logic [4:0] lowest_set(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = POS_N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : lowest_set

endpackage : vic_pkg

// file: logic/vic_prio_if.sv
// Request and in-service vectors to the priority resolver and its verdict back
`timescale 1ns/100ps
interface vic_prio_if;
   logic [15:0] request;
   logic [15:0] in_service;
   logic [15:0] cascade;
   logic fixed_mode;
   logic win_valid;
   logic [3:0] win_idx;
   logic raise;

   modport ctrl (
      output request,
      output in_service,
      output cascade,
      output fixed_mode,
      input win_valid,
      input win_idx,
      input raise
   );

   modport resolver (
      input request,
      input in_service,
      input cascade,
      input fixed_mode,
      output win_valid,
      output win_idx,
      output raise
   );
endinterface : vic_prio_if

// file: logic/vic_prio_resolver.sv
// Combinational priority resolver: winning position and interrupt raise decision
`timescale 1ns/100ps
module vic_prio_resolver (
   vic_prio_if.resolver prio
);
   logic [4:0] req_first;
   logic [4:0] srv_first;

   always_comb begin
      req_first = vic_pkg::lowest_set(prio.request);
      srv_first = vic_pkg::lowest_set(prio.in_service);
      prio.win_valid = req_first[4];
      prio.win_idx = req_first[3:0];
      prio.raise = 1'b0;
      if (req_first[4]) begin
         if (!srv_first[4]) begin
            prio.raise = 1'b1; // RULE17
         end else if (req_first[3:0] < srv_first[3:0]) begin
            prio.raise = 1'b1; // RULE24
         end else if (prio.fixed_mode && (req_first[3:0] == srv_first[3:0])
                      && prio.cascade[req_first[3:0]]) begin
            prio.raise = 1'b1; // RULE22
         end else begin
            prio.raise = 1'b0; // RULE21
         end
      end
   end
endmodule : vic_prio_resolver

// file: logic/vectored_interrupt_cascade_unit.sv
// Interrupt request, acknowledge and return sequencing with cascade support
//
// Overview of operation
// RULE1: Host reads master vector at fixed acknowledge address
// RULE2: Return cycle lets device re-prioritize pending requests
// RULE3: Single unit: software keeps vector base top bit zero
// RULE4: Negative vector marks a cascaded source
// RULE5: Up to 16 slaves, 256 sources total
// RULE6: Avoid cascading position zero
// RULE7: Host chip select decoding keeps low bits zero
// RULE8: Cascade flags plus hidden 4-bit counter per position
// RULE9: Cascaded acknowledge returns negative cascade index
// RULE10: Host acknowledges slave next; vector unsigned
// RULE11: Return on cascaded source gives negative index
// RULE12: Host follows with slave return, ignores byte
// RULE13: Pending byte writes set or clear software interrupts
// RULE14: Mask bit blocks position from requesting
// RULE15: Counter outputs are hardware interrupt sources
// RULE16: Freeze stops hardware setting pending bits
// RULE17: Raise output when unmasked request outranks service
// RULE18: Acknowledge clears pending, sets in-service
// RULE19: Fixed mode acknowledge of cascade increments counter
// RULE20: In-service holds until return and counter zero
// RULE21: In-service keeps output quiet unless outranked
// RULE22: Cascaded in-service does not block equal priority
// RULE23: Host takes low output as pending request
// RULE24: Fixed ranking zero highest, lower ones inhibited
// RULE25: Edges during freeze are held, then pended
// RULE26: Position number fills low nibble of vector
`timescale 1ns/100ps
module vectored_interrupt_cascade_unit (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [15:0] irq_pin_i,
   input wire logic [15:0] counter_irq_i,
   input wire logic acknowledge_cycle_i,
   input wire logic return_cycle_i,
   output logic [7:0] vector_o,
   output logic vector_valid_o,
   output logic int_n_o
);
   // ==========================================================
   // State
   // ==========================================================
   logic [15:0] pin_s1_q;
   logic [15:0] pin_s2_q;
   logic [15:0] pin_prev_q;
   logic [15:0] pending_flags_q;
   logic [15:0] pending_flags_d;
   logic [15:0] in_service_flags_q;
   logic [15:0] in_service_flags_d;
   logic [15:0] position_mask_q;
   logic [15:0] position_mask_d;
   logic [15:0] cascade_position_flags_q;
   logic [15:0] cascade_position_flags_d;
   logic [15:0] frozen_hold_q;
   logic [15:0] frozen_hold_d;
   logic [7:0] software_vector_base_q;
   logic [7:0] software_vector_base_d;
   logic [7:0] mode_control_reg_q;
   logic [7:0] mode_control_reg_d;
   logic [3:0] service_cnt_q [16]; // RULE5
   logic [3:0] service_cnt_d [16];
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [7:0] vector_q;
   logic [7:0] vector_d;
   logic vector_valid_q;
   logic vector_valid_d;
   logic int_n_q;
   logic int_n_d;

   logic freeze_gate;
   logic fixed_mode;
   logic [15:0] pin_edge;
   logic [15:0] hw_set;
   logic [4:0] ret_first;
   logic [3:0] ret_idx;
   logic [3:0] cnt_next;

   vic_prio_if prio ();

   vic_prio_resolver u_resolver (
      .prio(prio.resolver)
   );

   assign freeze_gate = mode_control_reg_q[vic_pkg::MODE_FREEZE_BIT];
   assign fixed_mode = mode_control_reg_q[vic_pkg::MODE_FIXED_BIT];
   assign prio.request = pending_flags_q & ~position_mask_q; // RULE14
   assign prio.in_service = in_service_flags_q;
   assign prio.cascade = cascade_position_flags_q;
   assign prio.fixed_mode = fixed_mode;

   // ==========================================================
   // Hardware request capture
   // ==========================================================
   assign pin_edge = pin_s2_q & ~pin_prev_q;
   // Slave outputs are levels so that nested slave requests re-pend
   assign hw_set = (pin_edge & ~cascade_position_flags_q)
                 | (pin_s2_q & cascade_position_flags_q)
                 | counter_irq_i; // RULE15

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pin_s1_q <= vic_pkg::RST_FLAGS;
         pin_s2_q <= vic_pkg::RST_FLAGS;
         pin_prev_q <= vic_pkg::RST_FLAGS;
      end else begin
         pin_s1_q <= irq_pin_i;
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      pending_flags_d = pending_flags_q;
      in_service_flags_d = in_service_flags_q;
      position_mask_d = position_mask_q;
      cascade_position_flags_d = cascade_position_flags_q;
      frozen_hold_d = frozen_hold_q;
      software_vector_base_d = software_vector_base_q;
      mode_control_reg_d = mode_control_reg_q;
      service_cnt_d = service_cnt_q;
      rdata_d = vic_pkg::RST_BYTE;
      vector_d = vector_q;
      vector_valid_d = 1'b0;
      ret_first = vic_pkg::lowest_set(in_service_flags_q);
      ret_idx = ret_first[3:0];
      cnt_next = service_cnt_q[ret_idx] - 4'h1;

      // Software writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            vic_pkg::OFS_VBASE: software_vector_base_d = reg_wdata_i;
            vic_pkg::OFS_PEND_L: pending_flags_d[7:0] = reg_wdata_i; // RULE13
            vic_pkg::OFS_PEND_H: pending_flags_d[15:8] = reg_wdata_i; // RULE13
            vic_pkg::OFS_INSRV_L: in_service_flags_d[7:0] = reg_wdata_i;
            vic_pkg::OFS_INSRV_H: in_service_flags_d[15:8] = reg_wdata_i;
            vic_pkg::OFS_MASK_L: position_mask_d[7:0] = reg_wdata_i;
            vic_pkg::OFS_MASK_H: position_mask_d[15:8] = reg_wdata_i;
            vic_pkg::OFS_CASC_L: cascade_position_flags_d[7:0] = reg_wdata_i; // RULE8
            vic_pkg::OFS_CASC_H: cascade_position_flags_d[15:8] = reg_wdata_i; // RULE8
            vic_pkg::OFS_MODE: mode_control_reg_d = reg_wdata_i & vic_pkg::MODE_USED;
            default: ;
         endcase
      end

      // Software reads
      if (reg_rd_i) begin
         case (reg_addr_i)
            vic_pkg::OFS_HVCT: rdata_d = {software_vector_base_q[7:4], prio.win_idx};
            vic_pkg::OFS_VBASE: rdata_d = software_vector_base_q;
            vic_pkg::OFS_PEND_L: rdata_d = pending_flags_q[7:0];
            vic_pkg::OFS_PEND_H: rdata_d = pending_flags_q[15:8];
            vic_pkg::OFS_INSRV_L: rdata_d = in_service_flags_q[7:0];
            vic_pkg::OFS_INSRV_H: rdata_d = in_service_flags_q[15:8];
            vic_pkg::OFS_MASK_L: rdata_d = position_mask_q[7:0];
            vic_pkg::OFS_MASK_H: rdata_d = position_mask_q[15:8];
            vic_pkg::OFS_CASC_L: rdata_d = cascade_position_flags_q[7:0];
            vic_pkg::OFS_CASC_H: rdata_d = cascade_position_flags_q[15:8];
            vic_pkg::OFS_MODE: rdata_d = mode_control_reg_q;
            default: rdata_d = vic_pkg::RST_BYTE;
         endcase
      end

      // Acknowledge cycle
      if (acknowledge_cycle_i) begin
         vector_valid_d = 1'b1;
         if (prio.win_valid) begin
            pending_flags_d[prio.win_idx] = 1'b0; // RULE18
            in_service_flags_d[prio.win_idx] = 1'b1; // RULE18
            if (cascade_position_flags_q[prio.win_idx]) begin
               vector_d = {vic_pkg::CASC_TOP, prio.win_idx}; // RULE4 RULE9 RULE10
               if (fixed_mode) begin
                  service_cnt_d[prio.win_idx] = service_cnt_q[prio.win_idx] + 4'h1; // RULE19
               end
            end else begin
               vector_d = {software_vector_base_q[7:4], prio.win_idx}; // RULE26
            end
         end else begin
            vector_d = {software_vector_base_q[7:4], vic_pkg::SPURIOUS_IDX};
         end
      end else if (return_cycle_i) begin
         // Return cycle counts down the top in-service position's counter and retires it at zero
         vector_valid_d = 1'b1; // RULE2
         if (ret_first[4]) begin
            if (cascade_position_flags_q[ret_idx]) begin
               vector_d = {vic_pkg::CASC_TOP, ret_idx}; // RULE11
            end else begin
               vector_d = {software_vector_base_q[7:4], ret_idx}; // RULE26
            end
            if (service_cnt_q[ret_idx] != vic_pkg::RST_CNT) begin
               service_cnt_d[ret_idx] = cnt_next; // RULE20
               if (cnt_next == vic_pkg::RST_CNT) begin
                  in_service_flags_d[ret_idx] = 1'b0; // RULE20
               end
            end else begin
               in_service_flags_d[ret_idx] = 1'b0; // RULE20
            end
         end else begin
            vector_d = {software_vector_base_q[7:4], vic_pkg::SPURIOUS_IDX};
         end
      end

      // Hardware sets win over any clear in the same cycle
      if (freeze_gate) begin
         frozen_hold_d = frozen_hold_q | hw_set; // RULE16 RULE25
      end else begin
         pending_flags_d = pending_flags_d | hw_set | frozen_hold_q; // RULE25
         frozen_hold_d = vic_pkg::RST_FLAGS;
      end

      int_n_d = ~prio.raise; // RULE17 RULE21
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pending_flags_q <= vic_pkg::RST_FLAGS;
         in_service_flags_q <= vic_pkg::RST_FLAGS;
         position_mask_q <= vic_pkg::RST_MASK;
         cascade_position_flags_q <= vic_pkg::RST_FLAGS;
         frozen_hold_q <= vic_pkg::RST_FLAGS;
         software_vector_base_q <= vic_pkg::RST_VBASE;
         mode_control_reg_q <= vic_pkg::RST_MODE;
         for (int i = 0; i < vic_pkg::POS_N; i++) begin
            service_cnt_q[i] <= vic_pkg::RST_CNT;
         end
         rdata_q <= vic_pkg::RST_BYTE;
         vector_q <= vic_pkg::RST_BYTE;
         vector_valid_q <= 1'b0;
         int_n_q <= 1'b1;
      end else begin
         pending_flags_q <= pending_flags_d;
         in_service_flags_q <= in_service_flags_d;
         position_mask_q <= position_mask_d;
         cascade_position_flags_q <= cascade_position_flags_d;
         frozen_hold_q <= frozen_hold_d;
         software_vector_base_q <= software_vector_base_d;
         mode_control_reg_q <= mode_control_reg_d;
         service_cnt_q <= service_cnt_d;
         rdata_q <= rdata_d;
         vector_q <= vector_d;
         vector_valid_q <= vector_valid_d;
         int_n_q <= int_n_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign vector_o = vector_q;
   assign vector_valid_o = vector_valid_q;
   assign int_n_o = int_n_q;

endmodule : vectored_interrupt_cascade_unit

// file: tb/vic_asserts.sv
// Port checker for the interrupt cascade unit
`timescale 1ns/100ps
module vic_asserts (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [15:0] irq_pin_i,
   input wire logic [15:0] counter_irq_i,
   input wire logic acknowledge_cycle_i,
   input wire logic return_cycle_i,
   input wire logic [7:0] vector_o,
   input wire logic vector_valid_o,
   input wire logic int_n_o
);
   logic [3:0] base_q;
   logic [15:0] mask_q;
   logic [2:0] frz_q;
   logic [3:0] act_q;
   logic cyc;
   logic wr;
   assign cyc = acknowledge_cycle_i | return_cycle_i;
   assign wr = reg_wr_i;
   // ==========================================================
   // Shadows: vector base, mask, freeze age, recent activity
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         base_q <= 4'h0;
         mask_q <= 16'hFFFF;
         frz_q <= 3'h0;
         act_q <= 4'h0;
      end else begin
         if (wr && reg_addr_i == vic_pkg::OFS_VBASE) base_q <= reg_wdata_i[7:4];
         if (wr && reg_addr_i == vic_pkg::OFS_MASK_L) mask_q[7:0] <= reg_wdata_i;
         if (wr && reg_addr_i == vic_pkg::OFS_MASK_H) mask_q[15:8] <= reg_wdata_i;
         if (wr && reg_addr_i == vic_pkg::OFS_MODE) frz_q <= {2'h0, reg_wdata_i[3]};
         else if (frz_q != 3'h0 && frz_q != 3'h7) frz_q <= frz_q + 3'h1;
         if (wr || cyc || |counter_irq_i || |irq_pin_i) act_q <= 4'h8;
         else if (act_q != 4'h0) act_q <= act_q - 4'h1;
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   chk_cycle_answer: assert property (cyc |=> vector_valid_o)
      else $error("no vector after bus cycle");
   chk_valid_cause: assert property (vector_valid_o |-> $past(cyc))
      else $error("vector valid without bus cycle");
   chk_vector_hold: assert property (!vector_valid_o |-> $stable(vector_o))
      else $error("vector changed outside answer");
   chk_vector_base: assert property (vector_valid_o && vector_o[7:4] != 4'hF
      |-> vector_o[7:4] == base_q)
      else $error("vector top nibble not from base");
   chk_mask_quiet: assert property ($past(mask_q) == 16'hFFFF && mask_q == 16'hFFFF
      |-> int_n_o)
      else $error("request while all masked");
   chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside read answer");
   chk_freeze_hold: assert property ($fell(int_n_o) && frz_q == 3'h7 |-> $past(wr | cyc)
      || $past(wr | cyc, 2) || $past(wr | cyc, 3))
      else $error("hardware request while frozen");
   chk_int_cause: assert property ($fell(int_n_o) |-> act_q != 4'h0)
      else $error("request without cause");
   cover property (acknowledge_cycle_i && !int_n_o);
   cover property (vector_valid_o && vector_o[7:4] == vic_pkg::CASC_TOP);
   cover property (frz_q == 3'h7);
endmodule : vic_asserts

bind vectored_interrupt_cascade_unit vic_asserts chk (.ref_clk_i(ref_clk_i),
   .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .irq_pin_i(irq_pin_i), .counter_irq_i(counter_irq_i),
   .acknowledge_cycle_i(acknowledge_cycle_i), .return_cycle_i(return_cycle_i),
   .vector_o(vector_o), .vector_valid_o(vector_valid_o), .int_n_o(int_n_o));

// file: tb/host_cpu_model.sv
// Host processor model running acknowledge and return cycles
`timescale 1ns/100ps
module host_cpu_model (
   input wire logic ref_clk_i,
   input wire logic int_n_i,
   input wire logic [7:0] vector_i,
   input wire logic vector_valid_i,
   output logic ack_o,
   output logic ret_o,
   output logic req_seen_o
);
   logic slave_next;
   assign req_seen_o = (int_n_i === 1'b0);
   initial begin
      ack_o = 1'b0;
      ret_o = 1'b0;
      slave_next = 1'b0;
   end
   // Strobe one cycle, byte taken in the cycle after; select is decoded by the strobe
   task automatic bus_cycle(input logic is_ack, output logic [7:0] v, output logic ok);
      @(posedge ref_clk_i);
      ack_o <= is_ack;
      ret_o <= !is_ack;
      @(posedge ref_clk_i);
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      #1;
      v = vector_i;
      ok = vector_valid_i;
      // Negative index: next cycle goes to a slave, its byte unused
      slave_next = v[7];
   endtask : bus_cycle
endmodule : host_cpu_model

// file: tb/tb_top.sv
// Self-checking bench for the interrupt cascade unit
`timescale 1ns/100ps
module tb_top;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [4:0] reg_addr_i = 5'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [15:0] irq_pin_i = 16'h0000;
   logic [15:0] counter_irq_i = 16'h0000;
   logic [7:0] reg_rdata_o;
   logic [7:0] vector_o;
   logic vector_valid_o;
   logic int_n_o;
   logic ack;
   logic ret;
   int errors = 0;
   int checked = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   vectored_interrupt_cascade_unit DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_pin_i(irq_pin_i),
      .counter_irq_i(counter_irq_i), .acknowledge_cycle_i(ack), .return_cycle_i(ret),
      .vector_o(vector_o), .vector_valid_o(vector_valid_o), .int_n_o(int_n_o));
   host_cpu_model host (.ref_clk_i(ref_clk_i), .int_n_i(int_n_o), .vector_i(vector_o),
      .vector_valid_i(vector_valid_o), .ack_o(ack), .ret_o(ret), .req_seen_o());
   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      check("reg_rdata_o", reg_rdata_o, exp);
   endtask : rd
   task automatic cyc(input logic is_ack, input logic [7:0] exp);
      logic [7:0] v;
      logic ok;
      host.bus_cycle(is_ack, v, ok);
      check("vector_valid_o", ok, 1'b1);
      check("vector_o", v, exp);
   endtask : cyc
   task automatic int_is(input logic exp);
      int n;
      n = 0;
      repeat (6) @(posedge ref_clk_i);
      #1;
      while (int_n_o !== exp && n < 10) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("int_n_o", int_n_o, exp);
   endtask : int_is
   task automatic conclude;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      int_is(1'b1);
      rd(vic_pkg::OFS_MASK_H, 8'hFF);
      rd(vic_pkg::OFS_PEND_L, 8'h00);
      rd(5'h1F, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_soft;
      wr(vic_pkg::OFS_VBASE, 8'h50);
      wr(vic_pkg::OFS_PEND_L, 8'h28);
      int_is(1'b1);
      wr(vic_pkg::OFS_MASK_L, 8'hD5);
      int_is(1'b0);
      rd(vic_pkg::OFS_HVCT, 8'h53);
      cyc(1'b1, 8'h53);
      rd(vic_pkg::OFS_INSRV_L, 8'h08);
      int_is(1'b1);
      wr(vic_pkg::OFS_PEND_L, 8'h22);
      int_is(1'b0);
      cyc(1'b1, 8'h51);
      cyc(1'b0, 8'h51);
      int_is(1'b1);
      cyc(1'b0, 8'h53);
      int_is(1'b0);
      wr(vic_pkg::OFS_PEND_L, 8'h00);
      int_is(1'b1);
      $display("test soft done");
   endtask : t_soft
   task automatic t_freeze;
      wr(vic_pkg::OFS_MODE, 8'h08);
      rd(vic_pkg::OFS_MODE, 8'h08);
      wr(vic_pkg::OFS_MASK_L, 8'hEB);
      @(posedge ref_clk_i);
      irq_pin_i <= 16'h0004;
      int_is(1'b1);
      rd(vic_pkg::OFS_PEND_L, 8'h00);
      wr(vic_pkg::OFS_MODE, 8'h00);
      int_is(1'b0);
      rd(vic_pkg::OFS_PEND_L, 8'h04);
      cyc(1'b1, 8'h52);
      cyc(1'b0, 8'h52);
      @(posedge ref_clk_i);
      irq_pin_i <= 16'h0000;
      counter_irq_i <= 16'h0010;
      @(posedge ref_clk_i);
      counter_irq_i <= 16'h0000;
      int_is(1'b0);
      cyc(1'b1, 8'h54);
      cyc(1'b0, 8'h54);
      wr(vic_pkg::OFS_MASK_L, 8'hFF);
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_cascade;
      wr(vic_pkg::OFS_MODE, 8'h80);
      wr(vic_pkg::OFS_CASC_L, 8'h40);
      wr(vic_pkg::OFS_MASK_L, 8'hBF);
      @(posedge ref_clk_i);
      irq_pin_i <= 16'h0040;
      int_is(1'b0);
      cyc(1'b1, 8'hF6);
      @(posedge ref_clk_i);
      irq_pin_i <= 16'h0000;
      int_is(1'b0);
      cyc(1'b1, 8'hF6);
      cyc(1'b0, 8'hF6);
      rd(vic_pkg::OFS_INSRV_L, 8'h40);
      cyc(1'b0, 8'hF6);
      rd(vic_pkg::OFS_INSRV_L, 8'h00);
      int_is(1'b1);
      $display("test cascade done");
   endtask : t_cascade
   initial begin
      #200000;
      errors++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_soft();
      t_freeze();
      t_cascade();
      conclude();
   end
endmodule : tb_top
